/* iex_main.sv */
// Interrupt expansion block: groups, core lines, vectors
//
// Operation
// - Fourteen lines; lines 12, 13 from timers
// - Sixteen sources per group line, 192 total
// - Own pending flag and enable per source
// - Group flag, enable words; group acknowledge mask
// - Group sources deliver only through full flag/enable chain
// - Block and global mask disabled at reset
// - Per-source vector supplied from vector memory
// - Lowest pending line served first, then its lowest source
// - Each core instance configured independently
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module iex_main
    import iex_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // Register port
    input  wire iex_bus_s          bus_req,
    output logic      [DATA_W-1:0] rd_data,
    // Request sources
    input  wire logic [NSRC-1:0]   periph_req,
    input  wire logic [1:0]        timer_req,
    // Core side
    input  wire logic              int_take,
    output logic                   cpu_int,
    output logic                   vec_valid,
    output logic      [VID_W-1:0]  vec_id,
    output logic      [VEC_W-1:0]  vec_addr
);
    iex_state_s        st_reg;        // Registered state
    iex_state_s        st_next;       // Next state
    logic [NSRC+1:0]   edge_v;        // Rising request edges
    logic [LINES-1:0]  line_req;      // Lines flagged and enabled
    logic              line_found;    // Some line pending
    logic [3:0]        win_line;      // Winning core line
    logic [SRCS-1:0]   grp_req;       // Winning group sources
    logic              src_found;     // Source inside group
    logic [3:0]        win_src;       // Winning source
    logic              take_ok;       // Accepted take
    logic [VID_W-1:0]  vec_idx;       // Vector position fetched
    logic [DATA_W-1:0] reg_rd;        // Register read value
    logic              vec_wr;        // Vector memory write

    // Refuse package shapes the fixed index slices cannot serve
    if (LINES != GROUPS + 2 || (1 << 4) != SRCS) begin : g_shape_chk
        $error("iex_main line or group shape not supported");
    end
    // Refuse a vector table wider than its fetch index or bus word
    if ((1 << VID_W) < NVEC || VEC_W > DATA_W) begin : g_vec_chk
        $error("iex_main vector shape not supported");
    end

    // Address is a used word of a group register bank
    function automatic logic in_bank(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] base);
        return (a[ADDR_W-1:4] == base[ADDR_W-1:4]) && (int'(a[3:0]) < GROUPS);
    endfunction

    // Rising edges of synchronised requests
    assign edge_v = st_reg.s2 & ~st_reg.prev;

    // Core lines that may be taken
    assign line_req = st_reg.lflag & st_reg.len;

    // Line priority: lowest line number first
    iex_prio_enc #(
        .WIDTH (LINES),
        .IDX_W (4)
    ) u_line_enc (
        .req   (line_req),
        .found (line_found),
        .idx   (win_line)
    );

    // Sources of the winning group that are flagged and enabled
    always_comb begin
        grp_req = '0;
        if (int'(win_line) < GROUPS) begin
            grp_req = st_reg.gflag[win_line] & st_reg.gen[win_line];
        end
    end

    // Source priority inside the group
    iex_prio_enc #(
        .WIDTH (SRCS),
        .IDX_W (4)
    ) u_src_enc (
        .req   (grp_req),
        .found (src_found),
        .idx   (win_src)
    );

    // Take is honoured only while the request is shown
    assign take_ok = int_take && st_reg.cpu_int && line_found;

    // Vector position: group*16+source, then timer entries
    always_comb begin
        if (int'(win_line) < GROUPS) begin
            vec_idx = src_found ? {win_line, win_src} : SPUR_VEC;
        end else begin
            vec_idx = TMR_VEC + VID_W'(win_line - 4'(TMR1_LINE));
        end
    end

    // Register read value
    always_comb begin
        reg_rd = '0;
        if (bus_req.addr == OFS_CTRL) begin
            reg_rd[EN_BIT] = st_reg.en;
        end else if (bus_req.addr == OFS_GMASK) begin
            reg_rd[GMASK_BIT] = st_reg.gmask;
        end else if (bus_req.addr == OFS_ACK) begin
            reg_rd[GROUPS-1:0] = st_reg.ack;
        end else if (bus_req.addr == OFS_LFLAG) begin
            reg_rd[LINES-1:0] = st_reg.lflag;
        end else if (bus_req.addr == OFS_LEN) begin
            reg_rd[LINES-1:0] = st_reg.len;
        end else if (bus_req.addr == OFS_LAST) begin
            reg_rd[VID_W-1:0] = st_reg.vid;
        end else if (in_bank(bus_req.addr, OFS_GFLAG)) begin
            reg_rd[SRCS-1:0] = st_reg.gflag[bus_req.addr[3:0]];
        end else if (in_bank(bus_req.addr, OFS_GEN)) begin
            reg_rd[SRCS-1:0] = st_reg.gen[bus_req.addr[3:0]];
        end
    end

    // Vector table writes by software
    assign vec_wr = bus_req.wr && bus_req.addr[VEC_SEL];

    // Vector memory; read data of both ports are registered
    iex_vec_mem #(
        .DEPTH (NVEC),
        .WIDTH (VEC_W),
        .AW    (VID_W),
        .DW    (DATA_W)
    ) u_vec_mem (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .wr_en      (vec_wr),
        .a_rd       (bus_req.rd),
        .a_sel      (bus_req.addr[VEC_SEL]),
        .a_addr     (bus_req.addr[VID_W-1:0]),
        .wr_data    (bus_req.wdata[VEC_W-1:0]),
        .bypass     (reg_rd),
        .a_data_reg (rd_data),
        .b_addr     (vec_idx),
        .b_data_reg (vec_addr)
    );

    // Next state: bus writes, then takes, then hardware sets
    always_comb begin
        st_next = st_reg;
        // Two-flop synchronisers, sources and timers alike
        st_next.s1   = {timer_req, periph_req};
        st_next.s2   = st_reg.s1;
        st_next.prev = st_reg.s2;
        // Software writes; this instance alone holds them
        if (bus_req.wr) begin
            if (bus_req.addr == OFS_CTRL) begin
                st_next.en = bus_req.wdata[EN_BIT];
            end else if (bus_req.addr == OFS_GMASK) begin
                st_next.gmask = bus_req.wdata[GMASK_BIT];
            end else if (bus_req.addr == OFS_ACK) begin
                // Write one to release a group
                st_next.ack = st_reg.ack & ~bus_req.wdata[GROUPS-1:0];
            end else if (bus_req.addr == OFS_LFLAG) begin
                // Write one to clear a line flag
                st_next.lflag = st_reg.lflag & ~bus_req.wdata[LINES-1:0];
            end else if (bus_req.addr == OFS_LEN) begin
                st_next.len = bus_req.wdata[LINES-1:0];
            end else if (in_bank(bus_req.addr, OFS_GFLAG)) begin
                st_next.gflag[bus_req.addr[3:0]] = bus_req.wdata[SRCS-1:0];
            end else if (in_bank(bus_req.addr, OFS_GEN)) begin
                st_next.gen[bus_req.addr[3:0]] = bus_req.wdata[SRCS-1:0];
            end
        end
        // Take clears the served flags and masks further takes
        if (take_ok) begin
            st_next.lflag[win_line] = 1'b0;
            st_next.gmask           = 1'b1;
            if (int'(win_line) < GROUPS && src_found) begin
                st_next.gflag[win_line][win_src] = 1'b0;
            end
        end
        // Source edges set their own flag; set beats any clear
        for (int g = 0; g < GROUPS; g++) begin
            for (int s = 0; s < SRCS; s++) begin
                if (edge_v[g * SRCS + s]) begin
                    st_next.gflag[g][s] = 1'b1;
                end
            end
        end
        // Group reaches its line unless acknowledged or disabled
        for (int g = 0; g < GROUPS; g++) begin
            if (st_reg.en && !st_reg.ack[g] && |(st_reg.gflag[g] & st_reg.gen[g])) begin
                st_next.lflag[g] = 1'b1;
                st_next.ack[g]   = 1'b1;
            end
        end
        // Timers feed the two top lines directly
        if (edge_v[NSRC]) begin
            st_next.lflag[TMR1_LINE] = 1'b1;
        end
        if (edge_v[NSRC + 1]) begin
            st_next.lflag[TMR1_LINE + 1] = 1'b1;
        end
        // Vector hand-off one cycle after take
        st_next.vld = take_ok;
        if (take_ok) begin
            st_next.vid = vec_idx;
        end
        // Request to core: line flag, line enable, global mask
        st_next.cpu_int = |(st_next.lflag & st_next.len) && !st_next.gmask;
    end

    // State register; block and global mask come up disabled
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg       <= '0;
            st_reg.en    <= RST_EN;
            st_reg.gmask <= RST_GMASK;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state
    assign cpu_int   = st_reg.cpu_int;
    assign vec_valid = st_reg.vld;
    assign vec_id    = st_reg.vid;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // Masked core never sees a request
    a_mask_blocks_int: assert property (
        st_reg.gmask |-> !cpu_int
    ) else $error("interrupt shown while global mask set");

    // Request implies a flagged, enabled line
    a_int_chain: assert property (
        cpu_int |-> (|(st_reg.lflag & st_reg.len))
    ) else $error("interrupt without flagged enabled line");

    // Source edge leaves its flag set
    a_src_flag_set: assert property (
        edge_v[3] |=> st_reg.gflag[0][3]
    ) else $error("source edge lost");

    // Line rises only from an open, enabled group
    a_ack_gates_line: assert property (
        $rose(st_reg.lflag[0]) |-> $past(st_reg.en && !st_reg.ack[0]) && st_reg.ack[0]
    ) else $error("group line set while acknowledged");

    // Vector stands exactly one cycle after take
    a_vec_one_cycle: assert property (
        take_ok |=> vec_valid ##1 (!vec_valid || $past(take_ok))
    ) else $error("vector valid timing wrong");

    // Line zero pending wins over all others
    a_prio_lowest: assert property (
        take_ok && line_req[0] |=> vec_id < VID_W'(SRCS) || vec_id == SPUR_VEC
    ) else $error("lower priority served first");

    // Third group maps onto positions 32 to 47
    a_group_span: assert property (
        take_ok && win_line == 4'd2 && src_found |=> vec_id >= 8'h20 && vec_id < 8'h30
    ) else $error("group vector position wrong");

    // Timer edge sets its line within one cycle
    a_timer_line: assert property (
        edge_v[NSRC] |=> st_reg.lflag[TMR1_LINE]
    ) else $error("timer line not set");

    // Take masks the core until software reopens it
    a_take_masks: assert property (
        take_ok |=> st_reg.gmask && !cpu_int
    ) else $error("take left core unmasked");

    // No vector strobe without an accepted take
    a_idle_no_vec: assert property (
        !take_ok |=> !vec_valid
    ) else $error("vector strobe without take");

    // Vector position latched from the winner
    a_take_vec_pos: assert property (
        take_ok |=> vec_valid && vec_id == $past(vec_idx)
    ) else $error("vector position not latched");

    // Second timer line rises only from its own edge
    a_timer_bypass: assert property (
        $rose(st_reg.lflag[TMR1_LINE + 1]) |-> $past(edge_v[NSRC + 1])
    ) else $error("timer line set without edge");

    // Second timer served at its own table entry
    a_timer_vec: assert property (
        take_ok && win_line == 4'(TMR1_LINE + 1) |=> vec_id == TMR_VEC + 8'h01
    ) else $error("timer vector position wrong");

    // Disabled block forwards no group
    a_block_gates_grp: assert property (
        $rose(st_reg.ack[2]) |-> $past(st_reg.en)
    ) else $error("group forwarded while block disabled");

    // Forwarded group line comes with its acknowledge
    a_fwd_sets_ack: assert property (
        $rose(st_reg.lflag[2]) |-> st_reg.ack[2]
    ) else $error("group line set without acknowledge");

    // Acknowledge stays until software writes a one
    a_ack_holds: assert property (
        st_reg.ack[0] && !(bus_req.wr && bus_req.addr == OFS_ACK && bus_req.wdata[0]) |=> st_reg.ack[0]
    ) else $error("group acknowledge lost");

    // Served source flag is cleared by the take
    a_take_clears_src: assert property (
        take_ok && win_line == 4'd0 && win_src == 4'd7 && !edge_v[7] |=> !st_reg.gflag[0][7]
    ) else $error("served source flag kept");

    // Lowest pending source of a group wins
    a_prio_group: assert property (
        take_ok && win_line == 4'd0 && grp_req[3:0] == 4'b1000 |=> vec_id == 8'h03
    ) else $error("group source priority wrong");

    // Unmasked flagged enabled line is shown to the core
    a_unmask_shows: assert property (
        !st_reg.gmask && (|line_req) |-> cpu_int
    ) else $error("pending line not shown");

    // Scenarios
    c_take_group: cover property (take_ok && int'(win_line) < GROUPS);
    c_take_timer: cover property (take_ok && win_line == 4'(TMR1_LINE));
    c_ack_release: cover property (bus_req.wr && bus_req.addr == OFS_ACK && |st_reg.ack);
    c_set_on_clear: cover property (edge_v[0] && take_ok && win_line == 4'd0);
    c_take_timer2: cover property (take_ok && win_line == 4'(TMR1_LINE + 1));
endmodule

/* iex_pkg.sv */
// Constants and types of the interrupt expansion block
package iex_pkg;
    // Structure sizes
    localparam int GROUPS    = 12;
    localparam int SRCS      = 16;
    localparam int LINES     = 14;
    localparam int NSRC      = GROUPS * SRCS;
    localparam int TMR1_LINE = 12;
    localparam int NVEC      = NSRC + 3;
    localparam int VEC_W     = 22;
    localparam int VID_W     = 8;
    localparam int ADDR_W    = 9;
    localparam int DATA_W    = 32;
    // Vector entries for timers and spurious takes
    localparam logic [VID_W-1:0] TMR_VEC  = 8'hC0;
    localparam logic [VID_W-1:0] SPUR_VEC = 8'hC2;
    // Register word addresses
    localparam logic [ADDR_W-1:0] OFS_CTRL  = 9'h000;
    localparam logic [ADDR_W-1:0] OFS_GMASK = 9'h001;
    localparam logic [ADDR_W-1:0] OFS_ACK   = 9'h002;
    localparam logic [ADDR_W-1:0] OFS_LFLAG = 9'h003;
    localparam logic [ADDR_W-1:0] OFS_LEN   = 9'h004;
    localparam logic [ADDR_W-1:0] OFS_LAST  = 9'h005;
    localparam logic [ADDR_W-1:0] OFS_GFLAG = 9'h010;
    localparam logic [ADDR_W-1:0] OFS_GEN   = 9'h020;
    localparam int                VEC_SEL   = 8;
    // Field positions and reset values
    localparam int   EN_BIT    = 0;
    localparam int   GMASK_BIT = 0;
    localparam logic RST_EN    = 1'b0;
    localparam logic RST_GMASK = 1'b1;
    // Register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } iex_bus_s;
    // Whole state of the top block
    typedef struct packed {
        logic                         en;
        logic                         gmask;
        logic [GROUPS-1:0]            ack;
        logic [LINES-1:0]             lflag;
        logic [LINES-1:0]             len;
        logic [GROUPS-1:0][SRCS-1:0]  gflag;
        logic [GROUPS-1:0][SRCS-1:0]  gen;
        logic [NSRC+1:0]              s1;
        logic [NSRC+1:0]              s2;
        logic [NSRC+1:0]              prev;
        logic                         vld;
        logic [VID_W-1:0]             vid;
        logic                         cpu_int;
    } iex_state_s;
endpackage

/* iex_prio_enc.sv */
// Lowest-index-first priority encoder
`timescale 1ns/1ps
module iex_prio_enc #(
    parameter int WIDTH = 16,
    parameter int IDX_W = 4
) (
    // Request vector
    input  wire logic [WIDTH-1:0] req,
    // Winner
    output logic                  found,
    output logic [IDX_W-1:0]      idx
);
    // Refuse an index too narrow for the width
    if ((1 << IDX_W) < WIDTH) begin : g_chk
        $error("IDX_W too small for WIDTH");
    end

    // Scan downward so the lowest set bit wins
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = IDX_W'(i);
            end
        end
    end
endmodule

/* iex_vec_mem.sv */
// Vector memory with a bus port and a fetch port
`timescale 1ns/1ps
module iex_vec_mem #(
    parameter int DEPTH = 195,
    parameter int WIDTH = 22,
    parameter int AW    = 8,
    parameter int DW    = 32
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // Bus port
    input  wire logic             wr_en,
    input  wire logic             a_rd,
    input  wire logic             a_sel,
    input  wire logic [AW-1:0]    a_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [DW-1:0]    bypass,
    output logic      [DW-1:0]    a_data_reg,
    // Fetch port
    input  wire logic [AW-1:0]    b_addr,
    output logic      [WIDTH-1:0] b_data_reg
);
    // Refuse shapes the ports cannot serve
    if ((1 << AW) < DEPTH || DW < WIDTH) begin : g_chk
        $error("iex_vec_mem shape not supported");
    end

    logic [WIDTH-1:0] mem [DEPTH];    // Vector table
    logic             a_hit;          // Bus address inside table
    logic             b_hit;          // Fetch address inside table

    assign a_hit = a_sel && (int'(a_addr) < DEPTH);
    assign b_hit = int'(b_addr) < DEPTH;

    // Array writes; contents are not reset
    always_ff @(posedge core_clk) begin
        if (wr_en && a_hit) begin
            mem[a_addr] <= wr_data;
        end
    end

    // Registered read ports; bus port also carries register data
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            a_data_reg <= '0;
            b_data_reg <= '0;
        end else begin
            if (a_rd) begin
                a_data_reg <= a_sel ? (a_hit ? DW'(mem[a_addr]) : '0) : bypass;
            end
            b_data_reg <= b_hit ? mem[b_addr] : '0;
        end
    end
endmodule

/* iex_core_model.sv */
// Behavioural model of the core that takes expanded interrupts
`timescale 1ns/1ps
module iex_core_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Interrupt request from the block
    input  wire logic       cpu_int,
    // Cycles to wait before taking, 0 is prompt
    input  wire logic [3:0] lag,
    // Take pulse back to the block
    output logic            int_take
);
    logic [3:0] wait_reg;  // Cycles seen with request high

    // Take once the request has stood for lag cycles
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_reg <= 4'h0;
            int_take <= 1'b0;
        end else if (!cpu_int || int_take) begin
            // Request gone or just taken: one pulse only
            wait_reg <= 4'h0;
            int_take <= 1'b0;
        end else if (wait_reg == lag) begin
            int_take <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

/* iex_main_tb.sv */
// Self-checking testbench of the interrupt expansion block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
    $display("unexpected %s: expected %h, seen %h", nm, ex, got); end end
module iex_main_tb;
    import iex_pkg::*;
    // One table row: optional write, then a read
    typedef struct packed {
        logic              w;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] ex;
    } iex_row_s;
    logic              core_clk   = 1'b0;  // Core clock
    logic              arst_n     = 1'b0;  // Reset, active low
    iex_bus_s          bus_req    = '0;    // Register port request
    logic [DATA_W-1:0] rd_data;            // Read data
    logic [NSRC-1:0]   periph_req = '0;    // Peripheral requests
    logic [1:0]        timer_req  = 2'h0;  // Timer requests
    logic              int_take;           // Take from core model
    logic              cpu_int;            // Request to core
    logic              vec_valid;          // Vector strobe
    logic [VID_W-1:0]  vec_id;             // Vector position
    logic [VEC_W-1:0]  vec_addr;           // Vector contents
    logic [3:0]        lag        = 4'h0;  // Core take delay
    logic [DATA_W-1:0] got;                // Last read value
    int                err_count  = 0;     // Mismatches
    int                n_tests    = 0;     // Comparisons
    iex_row_s          rows [12];          // Ordinary register cases

    iex_main uut (.core_clk(core_clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
        .periph_req(periph_req), .timer_req(timer_req), .int_take(int_take), .cpu_int(cpu_int),
        .vec_valid(vec_valid), .vec_id(vec_id), .vec_addr(vec_addr));
    iex_core_model core (.core_clk(core_clk), .arst_n(arst_n), .cpu_int(cpu_int), .lag(lag),
        .int_take(int_take));

    // Free-running core clock
    always #5 core_clk = ~core_clk;

    // Vector word stored for position i
    function automatic logic [VEC_W-1:0] vv(input int i);
        return 22'h15_0000 + VEC_W'(i);
    endfunction

    // One-cycle register write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    // One-cycle read, data sampled in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        @(negedge core_clk);
        got = rd_data;
    endtask

    // Let the core take, then check the vector handed over
    task automatic take(input int i, input logic [3:0] lg);
        logic hit;
        int   k;
        @(posedge core_clk);
        lag <= lg;
        hit = 1'b0;
        for (k = 0; k < 60 && !hit; k++) begin
            @(negedge core_clk);
            hit = vec_valid;
        end
        `CHK("vec_valid", 1'b1, hit)
        `CHK("vec_id", VID_W'(i), vec_id)
        `CHK("vec_addr", vv(i), vec_addr)
        // Take masks the core globally
        `CHK("cpu_int after take", 1'b0, cpu_int)
    endtask

    // Line at the end of each test
    task automatic done(input string nm);
        $display("test %s finished, %0d mismatches so far", nm, err_count);
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("%0d comparisons, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #200_000;
        err_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        rows[0]  = '{1'b0, OFS_CTRL, 32'h0000_0000, 32'h0000_0000};
        rows[1]  = '{1'b0, OFS_GMASK, 32'h0000_0000, 32'h0000_0001};
        rows[2]  = '{1'b0, OFS_ACK, 32'h0000_0000, 32'h0000_0000};
        rows[3]  = '{1'b0, OFS_LFLAG, 32'h0000_0000, 32'h0000_0000};
        rows[4]  = '{1'b1, OFS_GEN + 9'h003, 32'hFFFF_FFFF, 32'h0000_FFFF};
        rows[5]  = '{1'b1, OFS_GFLAG + 9'h00B, 32'h0000_A5A5, 32'h0000_A5A5};
        rows[6]  = '{1'b1, OFS_GFLAG + 9'h00B, 32'h0000_0000, 32'h0000_0000};
        rows[7]  = '{1'b1, 9'h006, 32'hFFFF_FFFF, 32'h0000_0000};
        rows[8]  = '{1'b1, 9'h105, 32'hFFFF_FFFF, 32'h003F_FFFF};
        rows[9]  = '{1'b1, 9'h1C3, 32'hFFFF_FFFF, 32'h0000_0000};
        rows[10] = '{1'b1, OFS_LEN, 32'hFFFF_FFFF, 32'h0000_3FFF};
        rows[11] = '{1'b1, OFS_GEN + 9'h003, 32'h0000_0000, 32'h0000_0000};
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        `CHK("cpu_int at reset", 1'b0, cpu_int)
        // Register table
        foreach (rows[r]) begin
            if (rows[r].w) begin
                wr(rows[r].a, rows[r].d);
            end
            rd(rows[r].a);
            `CHK("register", rows[r].ex, got)
        end
        done("registers");
        // Vectors loaded before the block is enabled
        wr(9'h100 + 9'd3, 32'(vv(3)));
        wr(9'h100 + 9'd7, 32'(vv(7)));
        wr(9'h100 + 9'd32, 32'(vv(32)));
        wr(9'h100 + 9'(NSRC), 32'(vv(NSRC)));
        wr(9'h100 + 9'(NSRC + 1), 32'(vv(NSRC + 1)));
        wr(OFS_GEN, 32'h0000_0088);
        wr(OFS_GEN + 9'h002, 32'h0000_0001);
        wr(OFS_CTRL, 32'h0000_0001);
        wr(OFS_GMASK, 32'h0000_0000);
        // Three requests at once: lowest position wins
        @(posedge core_clk);
        periph_req[3]  <= 1'b1;
        periph_req[7]  <= 1'b1;
        periph_req[32] <= 1'b1;
        take(3, 4'h0);
        repeat (5) @(negedge core_clk);
        `CHK("cpu_int masked", 1'b0, cpu_int)
        rd(OFS_ACK);
        `CHK("ack", 32'h0000_0005, got)
        rd(OFS_GFLAG);
        `CHK("group 0 flags", 32'h0000_0080, got)
        wr(OFS_GMASK, 32'h0000_0000);
        take(32, 4'h5);
        wr(OFS_GMASK, 32'h0000_0000);
        wr(OFS_ACK, 32'h0000_0001);
        take(7, 4'h2);
        done("priority");
        // Timer line gated by its core line enable
        wr(OFS_GMASK, 32'h0000_0000);
        wr(OFS_LEN, 32'h0000_2FFF);
        @(posedge core_clk);
        timer_req[0] <= 1'b1;
        repeat (8) @(negedge core_clk);
        `CHK("cpu_int line off", 1'b0, cpu_int)
        rd(OFS_LFLAG);
        `CHK("line flags", 32'h0000_1000, got)
        wr(OFS_LFLAG, 32'h0000_1000);
        rd(OFS_LFLAG);
        `CHK("line flags cleared", 32'h0000_0000, got)
        @(posedge core_clk);
        timer_req[0] <= 1'b0;
        repeat (4) @(posedge core_clk);
        timer_req[0] <= 1'b1;
        repeat (6) @(posedge core_clk);
        wr(OFS_LEN, 32'h0000_3FFF);
        take(NSRC, 4'h1);
        // Second timer passes with the block disabled
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_GMASK, 32'h0000_0000);
        @(posedge core_clk);
        timer_req[1] <= 1'b1;
        take(NSRC + 1, 4'h0);
        done("timers");
        // Reset in mid-run
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        `CHK("cpu_int after reset", 1'b0, cpu_int)
        rd(OFS_CTRL);
        `CHK("enable after reset", 32'h0000_0000, got)
        rd(OFS_GMASK);
        `CHK("mask after reset", 32'h0000_0001, got)
        done("reset");
        end_of_test();
    end
endmodule
